// file: adcsf_defines.svh
/*
  timing-free constants of the converter status flag logic: field positions,
  reset values and shift lengths.
  assumes inclusion by bare name from the package file; the design module uses the macros without including it.
*/
`ifndef ADCSF_DEFINES_SVH
`define ADCSF_DEFINES_SVH

`define ADCSF_STATUS_ADDR     3'h0
`define ADCSF_DATA_ADDR       3'h3
`define ADCSF_STATUS_RESET    8'h80
`define ADCSF_BIT_READY       7
`define ADCSF_BIT_CLAMP       6
`define ADCSF_BIT_REF_MISSING 5
`define ADCSF_BIT_PARITY      4
`define ADCSF_BIT_ZERO        3
`define ADCSF_RESULT_W        24
`define ADCSF_STATUS_W        8
`define ADCSF_SHIFT_W         32
`define ADCSF_LEN_STATUS      6'h08
`define ADCSF_LEN_DATA        6'h18
`define ADCSF_LEN_DATA_STATUS 6'h20
`define ADCSF_RESULT_ONES     24'hFFFFFF

`endif

// file: adcsf_pkg.sv
/*
  types of the converter status flag logic.
  assumes the defines header is on the include path.
*/
`include "adcsf_defines.svh"

package adcsf_pkg;

  typedef enum logic {
    ADCSF_IDLE,
    ADCSF_SHIFT
  } adcsf_phase_t;

  typedef struct packed {
    logic                        ready;
    logic                        clamp;
    logic                        reference_missing_flag;
    logic                        parity;
    logic [2:0]                  result_channel_field;
    logic [`ADCSF_RESULT_W-1:0]  result;
    logic [`ADCSF_SHIFT_W-1:0]   shreg;
    logic [5:0]                  count;
    logic                        data_read;
    adcsf_phase_t                phase;
    logic                        restart_n_s1;
    logic                        restart_n_s2;
    logic                        ref_low_s1;
    logic                        ref_low_s2;
  } adcsf_state_t;

endpackage : adcsf_pkg

// file: adcsf_status_flags.sv
/*
  status word of the sigma-delta converter and its serial read-out shifter.
  assumes datapath strobes on the same clock and a serial front end that
  decodes commands and gives one shift enable per serial bit.
*/
// Summary of operation
// - loading a new result clears the ready flag.
// - finishing a data register read sets the ready flag.
// - an approaching data update sets the ready flag beforehand.
// - power-down, idle or low filter restart pin sets the ready flag.
// - the serial-out pin shows the ready flag between transfers.
// - the clamp flag changes only together with a ready flag update on load.
// - a clamped result sets the clamp flag.
// - an in-range stored result clears the clamp flag.
// - missing reference sets its flag and forces results to all ones.
// - a valid reference clears the missing-reference flag.
// - the missing-reference flag works only when detection is enabled.
// - with parity enabled, parity flag is one for odd ones count.
// - with appending on, each data read shifts out the status too.
// - status bit three always reads zero.
// - low three bits name the channel of the held result.
// - status word leaves most significant bit first, ready flag first.
// - reset loads the status word with hex 80.
module adcsf_status_flags
  import adcsf_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // datapath events
  input  wire logic        result_load,
  input  wire logic [23:0] result_data,
  input  wire logic        result_out_of_range,
  input  wire logic [2:0]  result_channel,
  input  wire logic        update_approach,
  input  wire logic        power_down_or_idle,
  // pins, asynchronous
  input  wire logic        filter_restart_n,
  input  wire logic        reference_low,
  // configuration bits
  input  wire logic        reference_detect_enable,
  input  wire logic        parity_check_enable,
  input  wire logic        append_status_to_result,
  // serial front end
  input  wire logic        read_start,
  input  wire logic [2:0]  read_address,
  input  wire logic        shift_enable,
  output logic             serial_out_ready,
  output logic             read_busy,
  output logic [7:0]       converter_status_word
);

  adcsf_state_t state;
  adcsf_state_t next_state;

  // bit three is tied low rather than stored
  function automatic logic [7:0] status_of(input adcsf_state_t s);
    status_of = {s.ready, s.clamp, s.reference_missing_flag, s.parity,
                 1'b0, s.result_channel_field};
  endfunction : status_of

  logic [`ADCSF_RESULT_W-1:0] stored;
  logic                       ref_missing;
  // one reset word keeps the reset branch and the documented value in step
  localparam logic [7:0]      reset_word = `ADCSF_STATUS_RESET;

  always_comb begin
    next_state = state;
    next_state.restart_n_s1 = filter_restart_n;
    next_state.restart_n_s2 = state.restart_n_s1;
    next_state.ref_low_s1   = reference_low;
    next_state.ref_low_s2   = state.ref_low_s1;
    // only the second stage of the pin synchronisers is looked at
    ref_missing = reference_detect_enable & state.ref_low_s2;
    next_state.reference_missing_flag = ref_missing;
    stored = ref_missing ? `ADCSF_RESULT_ONES : result_data;
    if (result_load) begin
      next_state.ready  = 1'b0;
      next_state.result = stored;
      next_state.clamp  = result_out_of_range | ref_missing;
      next_state.parity = parity_check_enable & (^stored);
      next_state.result_channel_field = result_channel;
    end
    unique case (state.phase)
      ADCSF_IDLE: begin
        if (read_start && read_address == `ADCSF_STATUS_ADDR) begin
          next_state.shreg     = {status_of(state), 24'h000000};
          next_state.count     = `ADCSF_LEN_STATUS;
          next_state.data_read = 1'b0;
          next_state.phase     = ADCSF_SHIFT;
        end else if (read_start && read_address == `ADCSF_DATA_ADDR) begin
          next_state.shreg     = {state.result, status_of(state)};
          next_state.count     = append_status_to_result ? `ADCSF_LEN_DATA_STATUS
                                                         : `ADCSF_LEN_DATA;
          next_state.data_read = 1'b1;
          next_state.phase     = ADCSF_SHIFT;
        end
      end
      ADCSF_SHIFT: begin
        // count runs down to one; that last shift ends the word
        if (shift_enable) begin
          next_state.shreg = {state.shreg[`ADCSF_SHIFT_W-2:0], 1'b0};
          next_state.count = state.count - 6'h01;
          if (state.count == 6'h01) begin
            next_state.phase = ADCSF_IDLE;
            if (state.data_read) begin
              next_state.ready = 1'b1;
            end
          end
        end
      end
    endcase
    // set sources win over the load clear
    if (update_approach || power_down_or_idle || !state.restart_n_s2) begin
      next_state.ready = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state.ready                  <= reset_word[`ADCSF_BIT_READY];
      state.clamp                  <= reset_word[`ADCSF_BIT_CLAMP];
      state.reference_missing_flag <= reset_word[`ADCSF_BIT_REF_MISSING];
      state.parity                 <= reset_word[`ADCSF_BIT_PARITY];
      state.result_channel_field   <= reset_word[2:0];
      state.result                 <= 24'h000000;
      state.shreg                  <= 32'h00000000;
      state.count                  <= 6'h00;
      state.data_read              <= 1'b0;
      state.phase                  <= ADCSF_IDLE;
      // synchronisers park at the idle pin levels, so no false restart follows
      state.restart_n_s1           <= 1'b1;
      state.restart_n_s2           <= 1'b1;
      state.ref_low_s1             <= 1'b0;
      state.ref_low_s2             <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // pin doubles as end-of-conversion marker when no transfer runs
  assign serial_out_ready = (state.phase == ADCSF_SHIFT) ? state.shreg[`ADCSF_SHIFT_W-1]
                                                         : state.ready;
  assign read_busy = (state.phase == ADCSF_SHIFT);
  assign converter_status_word = status_of(state);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ready flag and its pin
  chk_load_clears_ready: assert property (result_load && !update_approach &&
      !power_down_or_idle && state.restart_n_s2 && !(read_busy && shift_enable)
      |=> !state.ready) else $error("ready not cleared by load");
  chk_read_sets_ready: assert property (read_busy && state.data_read &&
      shift_enable && state.count == 6'h01 |=> state.ready)
    else $error("ready not set after read");
  chk_approach_ready: assert property (update_approach |=> state.ready)
    else $error("ready not set before update");
  chk_idle_ready: assert property (power_down_or_idle || !state.restart_n_s2
      |=> state.ready) else $error("ready not set in idle or restart");
  chk_pin_ready: assert property (!read_busy |-> serial_out_ready == state.ready)
    else $error("pin does not show ready");

  // error, reference, parity and channel fields
  chk_clamp_hold: assert property (!$past(result_load) |-> $stable(state.clamp))
    else $error("clamp changed without load");
  chk_clamp_set: assert property (result_load && result_out_of_range |=> state.clamp)
    else $error("clamp not set");
  chk_clamp_clear: assert property (result_load && !result_out_of_range &&
      !ref_missing |=> !state.clamp) else $error("clamp not cleared");
  chk_refmiss_ones: assert property (result_load && ref_missing
      |=> state.result == `ADCSF_RESULT_ONES) else $error("result not forced to ones");
  chk_refmiss_follow: assert property (reference_detect_enable && state.ref_low_s2
      |=> state.reference_missing_flag) else $error("missing reference not flagged");
  chk_refmiss_clear: assert property (!state.ref_low_s2
      |=> !state.reference_missing_flag) else $error("missing reference not cleared");
  chk_refmiss_off: assert property (!reference_detect_enable ##1
      !reference_detect_enable |-> !state.reference_missing_flag)
    else $error("reference flag without detect");
  chk_parity_calc: assert property (result_load |=> state.parity ==
      ($past(parity_check_enable) & (^state.result))) else $error("parity wrong");
  chk_parity_hold: assert property (!$past(result_load) |-> $stable(state.parity))
    else $error("parity changed without load");
  chk_bit3_zero: assert property (converter_status_word[`ADCSF_BIT_ZERO] == 1'b0)
    else $error("status bit three not zero");
  chk_chan_load: assert property (result_load
      |=> state.result_channel_field == $past(result_channel))
    else $error("channel field not loaded");
  chk_chan_hold: assert property (!$past(result_load)
      |-> $stable(state.result_channel_field)) else $error("channel changed without load");

  // serial read-out
  chk_status_first: assert property (!read_busy && read_start &&
      read_address == `ADCSF_STATUS_ADDR |=> serial_out_ready == $past(state.ready))
    else $error("ready flag not first out");
  chk_data_first: assert property (!read_busy && read_start &&
      read_address == `ADCSF_DATA_ADDR
      |=> serial_out_ready == $past(state.result[`ADCSF_RESULT_W-1]))
    else $error("data not first out");
  chk_append_len: assert property (!read_busy && read_start &&
      read_address == `ADCSF_DATA_ADDR && append_status_to_result
      |=> state.count == `ADCSF_LEN_DATA_STATUS) else $error("status not appended");
  chk_plain_len: assert property (!read_busy && read_start &&
      read_address == `ADCSF_DATA_ADDR && !append_status_to_result
      |=> state.count == `ADCSF_LEN_DATA) else $error("data length wrong");
  chk_shift_step: assert property (read_busy && shift_enable && state.count != 6'h01
      |=> read_busy && serial_out_ready == $past(state.shreg[`ADCSF_SHIFT_W-2]))
    else $error("shift order wrong");
  chk_busy_end: assert property (read_busy && shift_enable && state.count == 6'h01
      |=> !read_busy) else $error("transfer did not end");
  // a second start mid-transfer would tear the word apart
  chk_busy_refuse: assert property (read_busy && read_start && !shift_enable
      |=> read_busy && state.count == $past(state.count))
    else $error("start taken while busy");

  cov_status_read: cover property (read_start && read_address == `ADCSF_STATUS_ADDR
      ##[1:20] !read_busy);
  cov_data_append: cover property (read_start && read_address == `ADCSF_DATA_ADDR &&
      append_status_to_result ##1 read_busy);
  cov_clamped_load: cover property (result_load && result_out_of_range);
  cov_forced_ones: cover property (result_load && ref_missing);
  cov_ready_event: cover property (!state.ready && update_approach ##1 state.ready);

endmodule : adcsf_status_flags

// file: adcsf_host_model.sv
/*
  host model on the serial read port of the status flags.
  assumes the bench calls read_reg only while the port is idle.
*/
module adcsf_host_model (
  // clock
  input  wire logic  clock,
  // serial port
  input  wire logic  serial_out_ready,
  output logic       read_start,
  output logic [2:0] read_address,
  output logic       shift_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    read_start = 1'b0;
    read_address = 3'h7;
    shift_enable = 1'b0;
  end
  // address 0 is status, 3 is data; one bit per shift pulse
  task automatic read_reg(input logic [2:0] addr, input int nbits, output logic [31:0] word);
    word = 32'h0;
    @(posedge clock);
    #1 read_start = 1'b1;
    read_address = addr;
    @(posedge clock);
    #1 read_start = 1'b0;
    read_address = ~addr; // never left showing the old select
    for (int i = 0; i < nbits; i++) begin
      word = {word[30:0], serial_out_ready};
      shift_enable = 1'b1;
      @(posedge clock);
      #1 shift_enable = 1'b0;
      @(posedge clock);
      #1;
    end
  endtask : read_reg
endmodule : adcsf_host_model

// file: adcsf_status_flags_test.sv
/*
  self-checking bench of the status flags, host model on the serial side.
  assumes the host model and design files are compiled first.
*/
module adcsf_status_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst = 1'b1, ld = 1'b0, oor = 1'b0, appr = 1'b0, pdn = 1'b0;
  logic restart_n = 1'b1, rlow = 1'b0, rde = 1'b0, pce = 1'b0, app = 1'b0;
  logic [23:0] rd = 24'h0;
  logic [2:0] ch = 3'h0, raddr;
  logic rs, se, sor, busy;
  logic [7:0] sw;
  logic [31:0] w;
  int err_total = 0, n_tests = 0;
  always #4 clock = ~clock;
  adcsf_status_flags i_adcsf_status_flags (.clock(clock), .rst(rst), .result_load(ld),
    .result_data(rd), .result_out_of_range(oor), .result_channel(ch),
    .update_approach(appr), .power_down_or_idle(pdn), .filter_restart_n(restart_n),
    .reference_low(rlow), .reference_detect_enable(rde), .parity_check_enable(pce),
    .append_status_to_result(app), .read_start(rs), .read_address(raddr),
    .shift_enable(se), .serial_out_ready(sor), .read_busy(busy), .converter_status_word(sw));
  adcsf_host_model i_adcsf_host_model (.clock(clock), .serial_out_ready(sor),
    .read_start(rs), .read_address(raddr), .shift_enable(se));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic load(input logic [23:0] d, input logic [2:0] c, input logic o);
    @(posedge clock);
    #1 ld = 1'b1;
    rd = d;
    ch = c;
    oor = o;
    @(posedge clock);
    #1 ld = 1'b0;
  endtask : load
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic test_reads;
    chk("reset status", sw, 8'h80);
    chk("idle pin", sor, 1'b1);
    pce = 1'b1;
    app = 1'b1;
    load(24'h000007, 3'h5, 1'b0);
    chk("loaded status", sw, 8'h15);
    chk("ready pin", sor, 1'b0);
    fork
      i_adcsf_host_model.read_reg(3'h0, 8, w);
      begin
        repeat (3) @(posedge clock);
        #1 chk("busy during read", busy, 1'b1);
      end
    join
    chk("status read", w, 32'h15);
    i_adcsf_host_model.read_reg(3'h3, 32, w);
    chk("data plus status", w, 32'h00000715);
    chk("busy after read", busy, 1'b0);
    chk("ready after read", sw[7], 1'b1);
    i_adcsf_host_model.read_reg(3'h1, 0, w);
    chk("ignored select", busy, 1'b0);
    chk("ignored select ready", sw[7], 1'b1);
    $display("reads done");
  endtask : test_reads
  task automatic test_clamp;
    load(24'hFFFFFF, 3'h2, 1'b1);
    chk("clamped status", sw, 8'h42);
    pce = 1'b0;
    load(24'h000001, 3'h1, 1'b0);
    chk("in range status", sw, 8'h01);
    $display("clamp done");
  endtask : test_clamp
  task automatic test_reference;
    app = 1'b0;
    rde = 1'b1;
    rlow = 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("ref missing", sw[5], 1'b1);
    load(24'h000000, 3'h0, 1'b0);
    chk("forced status", sw, 8'h60);
    i_adcsf_host_model.read_reg(3'h3, 24, w);
    chk("forced data", w, 32'h00FFFFFF);
    rde = 1'b0;
    repeat (3) @(posedge clock);
    #1 chk("detect off", sw[5], 1'b0);
    rde = 1'b1;
    repeat (3) @(posedge clock);
    #1 rlow = 1'b0;
    repeat (3) @(posedge clock);
    #1 chk("ref valid", sw[5], 1'b0);
    $display("reference done");
  endtask : test_reference
  task automatic test_ready_events;
    for (int k = 0; k < 3; k++) begin
      load(24'h000003, 3'h4, 1'b0);
      chk("ready low", sw[7], 1'b0);
      appr = (k == 0);
      pdn = (k == 1);
      restart_n = (k != 2);
      @(posedge clock);
      #1 appr = 1'b0;
      repeat (3) @(posedge clock);
      #1 chk("ready set", sw[7], 1'b1);
      chk("event pin", sor, 1'b1);
      pdn = 1'b0;
      restart_n = 1'b1;
      repeat (3) @(posedge clock);
    end
    $display("ready events done");
  endtask : test_ready_events
  task automatic test_reset_again;
    @(posedge clock);
    #1 chk("before reset", sw, 8'h84);
    rst = 1'b1;
    @(posedge clock);
    #1 rst = 1'b0;
    chk("reset again status", sw, 8'h80);
    chk("reset again busy", busy, 1'b0);
    chk("reset again pin", sor, 1'b1);
    @(posedge clock);
    #1 chk("held after release", sw, 8'h80);
    $display("reset done");
  endtask : test_reset_again
  initial begin
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    test_reads();
    test_clamp();
    test_reference();
    test_ready_events();
    test_reset_again();
    end_of_test();
  end
endmodule : adcsf_status_flags_test
